// File: core/dma_channel_address_control.sv
// general dma channel plus adc result channel sharing one system bus request
`timescale 1ns/1ps
`include "dma_defines.svh"
module dma_channel_address_control
(
   input  wire logic               sys_clk_i,   // system clock
   input  wire logic               rst_i,       // async reset, active high
   input  wire logic [11:0]        reg_addr_i,  // register address
   input  wire logic [7:0]         reg_wdata_i, // register write data
   input  wire logic               reg_wr_i,    // register write strobe
   input  wire logic               reg_rd_i,    // register read strobe
   output logic      [7:0]         reg_rdata_o, // read data, cycle after strobe
   input  wire logic [7:0]         trig_i,      // trigger sources, pulses
   input  wire logic               adc_valid_i, // adc result ready pulse
   input  wire logic [3:0]         adc_input_i, // input the result belongs to
   input  wire logic [9:0]         adc_result_i, // adc conversion result
   output logic                    bus_req_o,   // system bus request to core
   input  wire logic               bus_ack_i,   // core grants the bus
   output dma_pkg::mem_req_type    mem_o,       // register file access
   input  wire logic [7:0]         mem_rdata_i, // register file read data
   input  wire logic [7:0]         per_data_i,  // byte from the peripheral
   output dma_pkg::per_out_type    per_o,       // byte toward the peripheral
   output logic                    dma_irq_o    // end of block interrupt pulse
);

   // software visible registers
   logic [7:0]             ctl_ff;       // channel control
   logic [7:0]             high_ff;      // shared high-address nibbles
   logic [7:0]             start_ff;     // original start low byte
   logic [7:0]             end_ff;       // end low byte
   logic [6:0]             adc_base_ff;  // adc block base
   logic [7:0]             adc_ctl_ff;   // adc channel control
   logic [11:0]            cur_ff;       // current transfer address
   // engine state
   dma_pkg::state_type     state_ff;     // sequencer state
   logic                   src_adc_ff;   // current job belongs to adc channel
   logic                   byte_ff;      // byte of the job on the bus now
   logic                   trig_pend_ff; // general request waiting
   logic                   adc_pend_ff;  // adc result waiting
   logic [9:0]             adc_res_ff;   // latched waiting result
   logic [3:0]             adc_in_ff;    // latched waiting input number
   logic [9:0]             adc_job_res_ff; // result being stored
   logic [3:0]             adc_job_in_ff;  // input being stored
   logic                   rd_dly_ff;    // read data returns this cycle
   logic                   rd_sel_ff;    // byte index of that read
   dma_pkg::mem_req_type   mem_ff;       // registered bus access
   dma_pkg::mem_req_type   nxt_mem;      // access to issue next
   dma_pkg::per_out_type   per_ff;       // registered peripheral byte
   logic [7:0]             rdata_ff;     // registered read data
   logic [7:0]             nxt_rdata;    // read mux
   logic                   irq_ff;       // interrupt pulse
   logic [11:0]            slot_addr;    // adc slot address
   logic [7:0]             slot_data;    // adc slot byte

   // build a 12-bit address from a nibble and a low byte
   function automatic logic [11:0] join_addr(input logic [3:0] hi, input logic [7:0] lo);
      join_addr = {hi, lo};
   endfunction : join_addr

   // register write hit on one address
   function automatic logic wr_hit(input logic [11:0] a);
      wr_hit = reg_wr_i && (reg_addr_i == a);
   endfunction : wr_hit

   logic [11:0] end_addr;   // last location of the block
   logic [11:0] start_addr; // original start to reload
   logic        at_end;     // current has reached the end
   logic        two_bytes;  // job moves two bytes
   logic        issue;      // an access goes out at this edge
   logic        issue_sel;  // byte index of that access
   logic        fin_gen;    // general job completes at this edge

   assign end_addr   = join_addr(high_ff[7:4], end_ff);
   assign start_addr = join_addr(high_ff[3:0], start_ff);
   assign at_end     = (cur_ff == end_addr);
   assign two_bytes  = src_adc_ff || ctl_ff[`DMA_CTL_WORD];
   assign issue      = ((state_ff == dma_pkg::ST_REQ) && bus_ack_i) ||
                       ((state_ff == dma_pkg::ST_XFER) && two_bytes && !byte_ff);
   assign issue_sel  = (state_ff == dma_pkg::ST_XFER);
   assign fin_gen    = (state_ff == dma_pkg::ST_FIN) && !src_adc_ff;

   // request is held from the grant wait until the last read has returned
   assign bus_req_o  = (state_ff != dma_pkg::ST_IDLE);
   assign mem_o      = mem_ff;
   assign per_o      = per_ff;
   assign reg_rdata_o = rdata_ff;
   assign dma_irq_o  = irq_ff;

   // adc slot formatting
   dma_adc_slot u_slot
   (
      .base_i     (adc_base_ff),
      .input_i    (adc_job_in_ff),
      .result_i   (adc_job_res_ff),
      .byte_sel_i (issue_sel),
      .addr_o     (slot_addr),
      .data_o     (slot_data)
   );

   // control register; software write wins over the single-pass clear
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         ctl_ff <= `DMA_CTL_RST;
      else if (wr_hit(`DMA_ADDR_CTL))
         ctl_ff <= reg_wdata_i;
      else if (fin_gen && at_end && !ctl_ff[`DMA_CTL_LOOP])
         ctl_ff[`DMA_CTL_EN] <= 1'b0;
   end

   // plain software registers
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         high_ff     <= `DMA_REG_RST;
         start_ff    <= `DMA_REG_RST;
         end_ff      <= `DMA_REG_RST;
         adc_base_ff <= 7'h00;
         adc_ctl_ff  <= `DMA_REG_RST;
      end
      else
      begin
         if (wr_hit(`DMA_ADDR_HIGH))
            high_ff <= reg_wdata_i;
         if (wr_hit(`DMA_ADDR_START))
            start_ff <= reg_wdata_i;
         if (wr_hit(`DMA_ADDR_END))
            end_ff <= reg_wdata_i;
         if (wr_hit(`DMA_ADDR_ADC_BASE))
            adc_base_ff <= reg_wdata_i[7:1];
         if (wr_hit(`DMA_ADDR_ADC_CTL))
            adc_ctl_ff <= reg_wdata_i;
      end
   end

   // current address: loaded by software, stepped or reloaded by hardware
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         cur_ff <= 12'h000;
      else if (wr_hit(`DMA_ADDR_START))
         cur_ff[7:0] <= reg_wdata_i;
      else if (wr_hit(`DMA_ADDR_HIGH))
         cur_ff[11:8] <= reg_wdata_i[3:0];
      else if (fin_gen && at_end)
         cur_ff <= start_addr;
      else if (fin_gen)
         // step matches the bytes just moved
         cur_ff <= cur_ff + (ctl_ff[`DMA_CTL_WORD] ? `DMA_STEP_WORD : `DMA_STEP_BYTE);
   end

   // end of block interrupt, one cycle
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         irq_ff <= 1'b0;
      else
         irq_ff <= fin_gen && at_end && ctl_ff[`DMA_CTL_IRQ];
   end

   // general request latch; a trigger in the idle cycle that starts the job is kept (set wins)
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         trig_pend_ff <= 1'b0;
      else if (!ctl_ff[`DMA_CTL_EN])
         trig_pend_ff <= 1'b0;
      else if (trig_i[ctl_ff[`DMA_CTL_SRC_MSB:`DMA_CTL_SRC_LSB]])
         trig_pend_ff <= 1'b1;
      else if ((state_ff == dma_pkg::ST_IDLE) && !adc_pend_ff)
         trig_pend_ff <= 1'b0;
   end

   // adc result latch; a newer result overwrites one not yet started
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         adc_pend_ff <= 1'b0;
         adc_res_ff  <= 10'h000;
         adc_in_ff   <= 4'h0;
      end
      else if (adc_valid_i && adc_ctl_ff[`DMA_ADC_EN])
      begin
         adc_pend_ff <= 1'b1;
         adc_res_ff  <= adc_result_i;
         adc_in_ff   <= adc_input_i;
      end
      else if (state_ff == dma_pkg::ST_IDLE)
         adc_pend_ff <= 1'b0;
   end

   // sequencer: adc results go first since they are lost if overwritten
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_ff       <= dma_pkg::ST_IDLE;
         src_adc_ff     <= 1'b0;
         byte_ff        <= 1'b0;
         adc_job_res_ff <= 10'h000;
         adc_job_in_ff  <= 4'h0;
      end
      else
         case (state_ff)
            dma_pkg::ST_IDLE:
            begin
               if (adc_pend_ff)
               begin
                  src_adc_ff     <= 1'b1;
                  adc_job_res_ff <= adc_res_ff;
                  adc_job_in_ff  <= adc_in_ff;
                  state_ff       <= dma_pkg::ST_REQ;
               end
               else if (trig_pend_ff && ctl_ff[`DMA_CTL_EN])
               begin
                  src_adc_ff <= 1'b0;
                  state_ff   <= dma_pkg::ST_REQ;
               end
            end
            dma_pkg::ST_REQ:
               // nothing moves before the core grants the bus
               if (bus_ack_i)
               begin
                  byte_ff  <= 1'b0;
                  state_ff <= dma_pkg::ST_XFER;
               end
            dma_pkg::ST_XFER:
               if (two_bytes && !byte_ff)
                  byte_ff <= 1'b1;
               else
                  state_ff <= dma_pkg::ST_FIN;
            dma_pkg::ST_FIN:
               state_ff <= dma_pkg::ST_IDLE;
            default:
               state_ff <= dma_pkg::ST_IDLE;
         endcase
   end

   // access to put on the bus at the next edge
   always_comb
   begin
      nxt_mem = '0;
      if (issue)
      begin
         if (src_adc_ff)
         begin
            nxt_mem.addr  = slot_addr;
            nxt_mem.wdata = slot_data;
            nxt_mem.wr    = 1'b1;
         end
         else
         begin
            nxt_mem.addr = cur_ff + {11'h000, issue_sel};
            if (ctl_ff[`DMA_CTL_DIR])
               nxt_mem.rd = 1'b1;
            else
            begin
               nxt_mem.wdata = per_data_i;
               nxt_mem.wr    = 1'b1;
            end
         end
      end
   end

   // registered bus access and peripheral hand-off of read bytes
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mem_ff    <= '0;
         rd_dly_ff <= 1'b0;
         rd_sel_ff <= 1'b0;
         per_ff    <= '0;
      end
      else
      begin
         mem_ff    <= nxt_mem;
         rd_dly_ff <= mem_ff.rd;
         rd_sel_ff <= mem_ff.addr[0] ^ cur_ff[0];
         per_ff.wr <= rd_dly_ff;
         if (rd_dly_ff)
         begin
            per_ff.data <= mem_rdata_i;
            per_ff.sel  <= rd_sel_ff;
         end
      end
   end

   // read mux; start low reads back the live current address
   always_comb
   begin
      case (reg_addr_i)
         `DMA_ADDR_CTL:      nxt_rdata = ctl_ff;
         `DMA_ADDR_HIGH:     nxt_rdata = {high_ff[7:4], cur_ff[11:8]};
         `DMA_ADDR_START:    nxt_rdata = cur_ff[7:0];
         `DMA_ADDR_END:      nxt_rdata = end_ff;
         `DMA_ADDR_ADC_BASE: nxt_rdata = {adc_base_ff, 1'b0};
         `DMA_ADDR_ADC_CTL:  nxt_rdata = adc_ctl_ff;
         default:            nxt_rdata = `DMA_UNMAPPED;
      endcase
   end

   // read data stand only in the cycle after the strobe
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         rdata_ff <= `DMA_UNMAPPED;
      else if (reg_rd_i)
         rdata_ff <= nxt_rdata;
      else
         rdata_ff <= `DMA_UNMAPPED;
   end

endmodule : dma_channel_address_control

// File: core/dma_defines.svh
// register offsets, control field positions, reset values and step sizes of the dma channel
`ifndef DMA_DEFINES_SVH
`define DMA_DEFINES_SVH

`define DMA_ADDR_CTL      12'hfb0
`define DMA_ADDR_HIGH     12'hfb1
`define DMA_ADDR_START    12'hfb3
`define DMA_ADDR_END      12'hfb4
`define DMA_ADDR_ADC_BASE 12'hfbd
`define DMA_ADDR_ADC_CTL  12'hfbe

`define DMA_CTL_EN        7
`define DMA_CTL_LOOP      6
`define DMA_CTL_DIR       5
`define DMA_CTL_IRQ       4
`define DMA_CTL_WORD      3
`define DMA_CTL_SRC_MSB   2
`define DMA_CTL_SRC_LSB   0
`define DMA_ADC_EN        7

`define DMA_CTL_RST       8'h00
`define DMA_REG_RST       8'h00
`define DMA_UNMAPPED      8'h00
`define DMA_STEP_BYTE     12'h001
`define DMA_STEP_WORD     12'h002

`endif

// File: core/dma_pkg.sv
// types shared by the dma channel files
package dma_pkg;

   // sequencer states of the shared bus engine
   typedef enum logic [1:0] {ST_IDLE, ST_REQ, ST_XFER, ST_FIN} state_type;

   // one access on the system bus toward the register file
   typedef struct packed {
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } mem_req_type;

   // one byte handed to the peripheral side
   typedef struct packed {
      logic [7:0] data;
      logic       sel;
      logic       wr;
   } per_out_type;

endpackage : dma_pkg

// File: core/dma_adc_slot.sv
// address and byte formatting of one adc result slot
`timescale 1ns/1ps
module dma_adc_slot
(
   input  wire logic [6:0]  base_i,    // upper seven bits of the block
   input  wire logic [3:0]  input_i,   // analog input number
   input  wire logic [9:0]  result_i,  // conversion result
   input  wire logic        byte_sel_i, // 0 = even byte, 1 = odd byte
   output logic      [11:0] addr_o,    // register file address
   output logic      [7:0]  data_o     // byte to store
);

   // slot low bits are twice the input number, so each input owns two bytes
   always_comb
   begin
      addr_o = {base_i, input_i, byte_sel_i};
      // msb part first, the two leftover bits left-justified in the odd byte
      data_o = byte_sel_i ? {result_i[1:0], 6'h00} : result_i[9:2];
   end

endmodule : dma_adc_slot

// File: tb/dma_core_model.sv
// processor core stand-in: bus grant and register file behind the dma channel
`timescale 1ns/1ps
module dma_core_model
(
   input  wire logic                 sys_clk_i,   // system clock
   input  wire logic                 rst_i,       // async reset, active high
   input  wire logic                 bus_req_i,   // request from the channel
   input  wire logic                 slow_i,      // 1 = grant three cycles late
   input  wire dma_pkg::mem_req_type mem_i,       // register file access
   output logic                      bus_ack_o,   // bus grant
   output logic      [7:0]           mem_rdata_o  // read data, cycle after rd
);
   logic [7:0] mem [0:4095]; // register file, bench may preload it
   logic [1:0] wait_ff;      // cycles the request has waited
   logic       rd_ff;        // read answer cycle
   logic [7:0] last_ff;      // last byte read

   // grant only while requested; slow mode makes the channel wait
   assign bus_ack_o = bus_req_i && (!slow_i || wait_ff == 2'd3);

   // wait counter restarts once the bus is handed back
   always @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
         wait_ff <= 2'd0;
      else if (!bus_req_i)
         wait_ff <= 2'd0;
      else if (wait_ff != 2'd3)
         wait_ff <= wait_ff + 2'd1;
   end

   // storage; outside the answer cycle the data lines flip so stale bytes never match
   always @(posedge sys_clk_i)
   begin
      if (mem_i.wr)
         mem[mem_i.addr] <= mem_i.wdata;
      rd_ff <= mem_i.rd;
      if (mem_i.rd)
         last_ff <= mem[mem_i.addr];
   end
   assign mem_rdata_o = rd_ff ? last_ff : ~last_ff;
endmodule : dma_core_model

// File: tb/dma_channel_address_control_asserts.sv
// concurrent checks on the dma channel ports
`timescale 1ns/1ps
`include "dma_defines.svh"
module dma_channel_address_control_asserts
(
   input  wire logic                 sys_clk_i,
   input  wire logic                 rst_i,
   input  wire logic [11:0]          reg_addr_i,
   input  wire logic [7:0]           reg_wdata_i,
   input  wire logic                 reg_wr_i,
   input  wire logic                 reg_rd_i,
   input  wire logic [7:0]           reg_rdata_o,
   input  wire logic                 adc_valid_i,
   input  wire logic [3:0]           adc_input_i,
   input  wire logic [9:0]           adc_result_i,
   input  wire logic                 bus_req_o,
   input  wire logic                 bus_ack_i,
   input  wire dma_pkg::mem_req_type mem_o,
   input  wire logic                 dma_irq_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   logic       gen_en_ff; // enable last written to control
   logic       adc_en_ff; // enable last written to adc control
   logic [6:0] base_ff;   // adc block base
   logic [3:0] quiet_ff;  // cycles with both channels off

   // shadow of software writes; a single-pass clear is not seen, which only delays quiet
   always_ff @(posedge sys_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         gen_en_ff <= 1'b0;
         adc_en_ff <= 1'b0;
         base_ff   <= 7'h00;
         quiet_ff  <= 4'h0;
      end
      else
      begin
         if (reg_wr_i && reg_addr_i == `DMA_ADDR_CTL)
            gen_en_ff <= reg_wdata_i[7];
         if (reg_wr_i && reg_addr_i == `DMA_ADDR_ADC_CTL)
            adc_en_ff <= reg_wdata_i[7];
         if (reg_wr_i && reg_addr_i == `DMA_ADDR_ADC_BASE)
            base_ff <= reg_wdata_i[7:1];
         if (gen_en_ff || adc_en_ff)
            quiet_ff <= 4'h0;
         else if (quiet_ff != 4'h8)
            quiet_ff <= quiet_ff + 4'h1;
      end
   end

   grant_wait_a: assert property ($rose(bus_req_o) && !bus_ack_i |=> !(mem_o.wr || mem_o.rd))
      else $error("access before bus grant");
   access_granted_a: assert property (mem_o.wr || mem_o.rd |-> bus_req_o && bus_ack_i)
      else $error("access without granted bus");
   bus_release_a: assert property (bus_req_o && bus_ack_i |-> ##[1:6] !bus_req_o)
      else $error("bus not handed back");
   rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
      else $error("read data outside answer cycle");
   ctl_readback_a: assert property (reg_wr_i && reg_addr_i == `DMA_ADDR_CTL ##2
      reg_rd_i && reg_addr_i == `DMA_ADDR_CTL |=> reg_rdata_o == $past(reg_wdata_i, 3))
      else $error("control readback differs");
   quiet_idle_a: assert property (quiet_ff == 4'h8 |-> !bus_req_o)
      else $error("disabled channel requested bus");
   irq_pulse_a: assert property (dma_irq_o |-> $past(bus_req_o) ##1 !dma_irq_o)
      else $error("interrupt not a transfer end pulse");
   adc_even_a: assert property (adc_valid_i && adc_en_ff |-> ##[1:8] mem_o.wr &&
      mem_o.addr == {base_ff, adc_input_i, 1'b0} && mem_o.wdata == adc_result_i[9:2])
      else $error("adc high byte slot wrong");
endmodule : dma_channel_address_control_asserts

bind dma_channel_address_control dma_channel_address_control_asserts u_dma_channel_address_control_asserts
(
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
   .adc_valid_i(adc_valid_i), .adc_input_i(adc_input_i), .adc_result_i(adc_result_i),
   .bus_req_o(bus_req_o), .bus_ack_i(bus_ack_i), .mem_o(mem_o), .dma_irq_o(dma_irq_o)
);

// File: tb/tb_top.sv
// register level bench for the dma channel
`timescale 1ns/1ps
module tb_top;
   logic                 sys_clk_i, rst_i, reg_wr_i, reg_rd_i, adc_valid_i, bus_req_o;
   logic                 bus_ack_i, dma_irq_o, slow;
   logic [11:0]          reg_addr_i;
   logic [7:0]           reg_wdata_i, reg_rdata_o, trig_i, mem_rdata_i, per_data_i;
   logic [7:0]           per_got [0:1]; // last byte handed to the peripheral, by byte index
   logic [3:0]           adc_input_i;
   logic [9:0]           adc_result_i;
   dma_pkg::mem_req_type mem_o;
   dma_pkg::per_out_type per_o;
   int                   bad_count, compares, irq_seen;

   dma_channel_address_control u_dma_channel_address_control
   (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .trig_i(trig_i),
      .adc_valid_i(adc_valid_i), .adc_input_i(adc_input_i), .adc_result_i(adc_result_i),
      .bus_req_o(bus_req_o), .bus_ack_i(bus_ack_i), .mem_o(mem_o), .mem_rdata_i(mem_rdata_i),
      .per_data_i(per_data_i), .per_o(per_o), .dma_irq_o(dma_irq_o)
   );
   dma_core_model u_dma_core_model
   (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus_req_i(bus_req_o), .slow_i(slow),
      .mem_i(mem_o), .bus_ack_o(bus_ack_i), .mem_rdata_o(mem_rdata_i)
   );

   // 100 ns clock
   initial
   begin
      sys_clk_i = 1'b0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   // watch interrupt pulses and bytes handed to the peripheral
   always @(posedge sys_clk_i)
   begin
      if (dma_irq_o === 1'b1)
         irq_seen++;
      if (per_o.wr === 1'b1)
         per_got[per_o.sel] <= per_o.data;
   end

   task conclude;
      $display("mismatches %0d, comparisons %0d", bad_count, compares);
      if (bad_count == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   task chk(input logic [11:0] got, input logic [11:0] exp);
      compares++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_i    <= 1'b0;
   endtask : wr

   task rd(input logic [11:0] a, input logic [7:0] exp);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_i   <= 1'b0;
      #1 chk(reg_rdata_o, exp);
   endtask : rd

   // pulse a trigger or adc result, then expect one bus tenure or none
   task fire(input bit adc, input logic [2:0] sel, input bit busy);
      logic seen;
      seen = 1'b0;
      @(posedge sys_clk_i);
      if (adc)
         adc_valid_i <= 1'b1;
      else
         trig_i <= 8'h01 << sel;
      @(posedge sys_clk_i);
      adc_valid_i <= 1'b0;
      trig_i      <= 8'h00;
      for (int i = 0; i < 60 && !(seen && bus_req_o === 1'b0); i++)
      begin
         @(negedge sys_clk_i);
         if (bus_req_o === 1'b1)
            seen = 1'b1;
      end
      compares++;
      if (seen !== busy || bus_req_o !== 1'b0)
      begin
         bad_count++;
         $display("unexpected at %0t: bus request pattern", $time);
      end
      repeat (4) @(posedge sys_clk_i);
   endtask : fire

   // bound on the whole run
   initial
   begin
      #5000000;
      bad_count++;
      $display("unexpected at %0t: run time limit", $time);
      conclude();
   end

   initial
   begin
      {rst_i, reg_wr_i, reg_rd_i, adc_valid_i, slow} = 5'b10000;
      {reg_addr_i, reg_wdata_i, trig_i, per_data_i} = 36'h0;
      adc_input_i  = 4'h0;
      adc_result_i = 10'h000;
      repeat (20) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(12'hfb0, 8'h00);
      wr(12'hfb0, 8'h5b);
      rd(12'hfb0, 8'h5b);
      wr(12'h000, 8'hff);
      rd(12'h000, 8'h00);
      fire(1'b0, 3'd3, 1'b0);
      // single pass, byte, interrupt on; crosses the high nibble
      wr(12'hfb1, 8'h32);
      wr(12'hfb3, 8'hfe);
      wr(12'hfb4, 8'h01);
      wr(12'hfb0, 8'h91);
      rd(12'hfb3, 8'hfe);
      for (int k = 0; k < 4; k++)
      begin
         per_data_i <= 8'h10 + 8'(k);
         slow       <= k[0];
         fire(1'b0, 3'd1, 1'b1);
         chk(u_dma_core_model.mem[12'h2fe + 12'(k)], 8'h10 + 8'(k));
      end
      chk(12'(irq_seen), 12'h001);
      rd(12'hfb3, 8'hfe);
      rd(12'hfb1, 8'h32);
      rd(12'hfb0, 8'h11);
      fire(1'b0, 3'd1, 1'b0);
      // looping word mode, no interrupt
      slow <= 1'b0;
      wr(12'hfb1, 8'h44);
      wr(12'hfb3, 8'h00);
      wr(12'hfb4, 8'h02);
      wr(12'hfb0, 8'hc9);
      fire(1'b0, 3'd1, 1'b1);
      rd(12'hfb3, 8'h02);
      fire(1'b0, 3'd1, 1'b1);
      rd(12'hfb3, 8'h00);
      rd(12'hfb0, 8'hc9);
      chk(12'(irq_seen), 12'h001);
      // register file to peripheral, single byte block
      u_dma_core_model.mem[12'h500] = 8'h3c;
      wr(12'hfb1, 8'h55);
      wr(12'hfb3, 8'h00);
      wr(12'hfb4, 8'h00);
      wr(12'hfb0, 8'ha1);
      fire(1'b0, 3'd1, 1'b1);
      chk(per_got[0], 8'h3c);
      rd(12'hfb0, 8'h21);
      // word read toward the peripheral: each byte must carry its own index
      u_dma_core_model.mem[12'h600] = 8'h5a;
      u_dma_core_model.mem[12'h601] = 8'ha5;
      wr(12'hfb1, 8'h66);
      wr(12'hfb3, 8'h00);
      wr(12'hfb4, 8'h00);
      wr(12'hfb0, 8'ha9);
      fire(1'b0, 3'd1, 1'b1);
      chk(per_got[0], 8'h5a);
      chk(per_got[1], 8'ha5);
      rd(12'hfb3, 8'h00);
      rd(12'hfb0, 8'h29);
      // adc result into its slot
      wr(12'hfbd, 8'h62);
      wr(12'hfbe, 8'h80);
      adc_input_i  <= 4'h5;
      adc_result_i <= 10'h2b7;
      fire(1'b1, 3'd0, 1'b1);
      chk(u_dma_core_model.mem[12'h62a], 8'had);
      chk(u_dma_core_model.mem[12'h62b], 8'hc0);
      rd(12'hfbd, 8'h62);
      // second reset in mid-run: control, high and adc control must come back as zero
      rst_i <= 1'b1;
      repeat (3) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      rd(12'hfb0, 8'h00);
      rd(12'hfb1, 8'h00);
      rd(12'hfbe, 8'h00);
      conclude();
   end
endmodule : tb_top
